/* hw/pin_select_pkg.sv */
`default_nettype none
package pin_select_pkg;
  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [5:0] CFG3_OFS = 6'h00;
  localparam logic [5:0] CFG4_OFS = 6'h04;
  localparam logic [5:0] CFG5_OFS = 6'h08;
  localparam logic [5:0] CFG6_OFS = 6'h0C;
  localparam logic [5:0] CTRL_OFS = 6'h10;
  localparam logic [5:0] THR_OFS = 6'h14;
  localparam logic [5:0] STAT_OFS = 6'h18;
  localparam logic [5:0] IST_OFS = 6'h1C;
  localparam logic [5:0] IMSK_OFS = 6'h20;
  // Field positions.
  localparam int CFG3_GPO_LVL = 0;
  localparam int CFG3_GPO_PP = 1;
  localparam int CFG3_FIN_MODE = 2;
  localparam int CFG3_GPO_SEL = 4;
  localparam int CFG4_NO_LASER_OFF_OUT = 7;
  localparam int CFG5_FLT_POL = 4;
  localparam int CFG6_TRS_SEL = 2;
  localparam int CFG6_LOS_POL = 3;
  localparam int CTRL_SRX = 0;
  localparam int CTRL_STX = 1;
  localparam int ST_RX_PIN = 0;
  localparam int ST_TX_PIN = 1;
  localparam int ST_DROP = 2;
  localparam int ST_TFLT = 3;
  localparam int ST_EXT = 4;
  localparam int ST_LASER_OFF_OUT = 5;
  localparam int IRQ_TFLT = 0;
  localparam int IRQ_LOSS = 1;
  // Reset values.
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] THR_RST = 8'h80;
  localparam logic [1:0] CTRL_RST = 2'h0;
endpackage : pin_select_pkg
`default_nettype wire

/* hw/optical_pin_select.sv */
`timescale 1ns/1ns
`default_nettype none
module optical_pin_select #(
  parameter int PWR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire logic internal_fault_i,
  input wire logic [PWR_W-1:0] received_power_input_i,
  input wire logic receiver_rate_pin_i,
  input wire logic transmitter_rate_pin_i,
  input wire logic external_fault_in_i,
  output logic laser_off_out_o,
  output logic laser_off_oe_n_o,
  output logic general_output_pin_o,
  output logic general_output_oe_n_o,
  input wire logic signal_drop_pin_i,
  output logic signal_drop_out_o,
  output logic signal_drop_oe_n_o,
  output logic transmit_fault_out_o,
  output logic transmit_fault_oe_n_o
);

  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic [7:0] cfg6;
    logic [1:0] ctrl;
    logic [PWR_W-1:0] thr;
    logic loss;
    logic flt;
    logic [1:0] rx_s;
    logic [1:0] tx_s;
    logic [1:0] ef_s;
    logic [1:0] dp_s;
    logic [1:0] ist;
    logic [1:0] imsk;
    logic irq;
    logic laser_off_out;
    logic laser_off_out_oe_n;
    logic general_output_pin;
    logic gpo_oe_n;
    logic drop_oe_n;
    logic tflt_oe_n;
    logic od_low;
  } state_s;

  state_s q;
  state_s d;

  logic req;
  logic fault_any;
  logic laser_off_out_lvl;
  logic rate_lvl;
  logic drop_lvl;
  logic tflt_lvl;
  logic [1:0] ev;
  logic [31:0] rd;
  logic [7:0] stat;

  assign req = avs_read_i | avs_write_i;

  always_comb begin
    d = q;
    rd = 32'h0000_0000;
    // Synchronisers: only the second stage is read by logic.
    d.rx_s = {q.rx_s[0], receiver_rate_pin_i};
    d.tx_s = {q.tx_s[0], transmitter_rate_pin_i};
    d.ef_s = {q.ef_s[0], external_fault_in_i};
    d.dp_s = {q.dp_s[0], signal_drop_pin_i};

    // The external input counts only while pin twelve is an input.
    fault_any = internal_fault_i |
                (q.cfg3[pin_select_pkg::CFG3_FIN_MODE] & q.ef_s[1]);
    d.flt = fault_any;

    laser_off_out_lvl = internal_fault_i &
               ~q.cfg4[pin_select_pkg::CFG4_NO_LASER_OFF_OUT];
    if (!q.cfg3[pin_select_pkg::CFG3_FIN_MODE]) begin
      d.laser_off_out = laser_off_out_lvl;
      d.laser_off_out_oe_n = 1'b0;
    end else begin
      d.laser_off_out = 1'b0;
      d.laser_off_out_oe_n = 1'b1;
    end

    // Equal power holds the previous decision, giving one code of margin.
    if (received_power_input_i < q.thr) begin
      d.loss = 1'b1;
    end else if (received_power_input_i > q.thr) begin
      d.loss = 1'b0;
    end

    if (q.cfg3[pin_select_pkg::CFG3_GPO_SEL]) begin
      rate_lvl = q.cfg3[pin_select_pkg::CFG3_GPO_LVL];
      if (q.cfg3[pin_select_pkg::CFG3_GPO_PP]) begin
        d.general_output_pin = rate_lvl;
        d.gpo_oe_n = 1'b0;
      end else begin
        d.general_output_pin = 1'b0;
        d.gpo_oe_n = rate_lvl;
      end
    end else begin
      rate_lvl = q.ctrl[pin_select_pkg::CTRL_SRX] | q.rx_s[1];
      d.general_output_pin = 1'b0;
      d.gpo_oe_n = rate_lvl;
    end

    if (q.cfg6[pin_select_pkg::CFG6_TRS_SEL]) begin
      drop_lvl = q.ctrl[pin_select_pkg::CTRL_STX] | q.tx_s[1];
    end else begin
      drop_lvl = q.loss ^ q.cfg6[pin_select_pkg::CFG6_LOS_POL];
    end
    // Releasing the pin gives the high level through the pull-up.
    d.drop_oe_n = drop_lvl;
    tflt_lvl = q.flt ^ q.cfg5[pin_select_pkg::CFG5_FLT_POL];
    d.tflt_oe_n = tflt_lvl;
    d.od_low = 1'b0;

    // Status: rate, drop and external pins as sampled; fault and shutdown bits are internal states.
    stat = 8'h00;
    stat[pin_select_pkg::ST_RX_PIN] = q.rx_s[1];
    stat[pin_select_pkg::ST_TX_PIN] = q.tx_s[1];
    stat[pin_select_pkg::ST_DROP] = q.dp_s[1];
    stat[pin_select_pkg::ST_TFLT] = q.flt;
    stat[pin_select_pkg::ST_EXT] = q.ef_s[1];
    stat[pin_select_pkg::ST_LASER_OFF_OUT] = q.laser_off_out;

    ev = 2'h0;
    ev[pin_select_pkg::IRQ_TFLT] = fault_any & ~q.flt;
    ev[pin_select_pkg::IRQ_LOSS] = d.loss & ~q.loss;

    case (avs_address_i)
      pin_select_pkg::CFG3_OFS: rd[7:0] = q.cfg3;
      pin_select_pkg::CFG4_OFS: rd[7:0] = q.cfg4;
      pin_select_pkg::CFG5_OFS: rd[7:0] = q.cfg5;
      pin_select_pkg::CFG6_OFS: rd[7:0] = q.cfg6;
      pin_select_pkg::CTRL_OFS: rd[1:0] = q.ctrl;
      pin_select_pkg::THR_OFS: rd[PWR_W-1:0] = q.thr;
      pin_select_pkg::STAT_OFS: rd[7:0] = stat;
      pin_select_pkg::IST_OFS: rd[1:0] = q.ist;
      pin_select_pkg::IMSK_OFS: rd[1:0] = q.imsk;
      default: rd = 32'h0000_0000;
    endcase

    // One wait cycle per access; the request is served when wait drops.
    d.wait_r = ~(req & q.wait_r);
    if (req & q.wait_r) begin
      d.rdata = avs_read_i ? rd : 32'h0000_0000;
    end

    d.ist = q.ist;
    if (avs_write_i & ~q.wait_r) begin
      case (avs_address_i)
        pin_select_pkg::CFG3_OFS: d.cfg3 = avs_writedata_i[7:0];
        pin_select_pkg::CFG4_OFS: d.cfg4 = avs_writedata_i[7:0];
        pin_select_pkg::CFG5_OFS: d.cfg5 = avs_writedata_i[7:0];
        pin_select_pkg::CFG6_OFS: d.cfg6 = avs_writedata_i[7:0];
        pin_select_pkg::CTRL_OFS: d.ctrl = avs_writedata_i[1:0];
        pin_select_pkg::THR_OFS: d.thr = avs_writedata_i[PWR_W-1:0];
        pin_select_pkg::IST_OFS: d.ist = q.ist & ~avs_writedata_i[1:0];
        pin_select_pkg::IMSK_OFS: d.imsk = avs_writedata_i[1:0];
        default: d.ist = d.ist;
      endcase
    end
    // A new event outweighs a clear in the same cycle.
    d.ist = d.ist | ev;
    d.irq = |(q.ist & q.imsk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.wait_r <= 1'b1;
      q.cfg3 <= pin_select_pkg::CFG_RST;
      q.cfg4 <= pin_select_pkg::CFG_RST;
      q.cfg5 <= pin_select_pkg::CFG_RST;
      q.cfg6 <= pin_select_pkg::CFG_RST;
      q.ctrl <= pin_select_pkg::CTRL_RST;
      q.thr <= PWR_W'(pin_select_pkg::THR_RST);
      q.laser_off_out_oe_n <= 1'b1;
      q.gpo_oe_n <= 1'b1;
      q.drop_oe_n <= 1'b1;
      q.tflt_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o = q.rdata;
  assign avs_waitrequest_o = q.wait_r;
  assign irq_o = q.irq;
  assign laser_off_out_o = q.laser_off_out;
  assign laser_off_oe_n_o = q.laser_off_out_oe_n;
  assign general_output_pin_o = q.general_output_pin;
  assign general_output_oe_n_o = q.gpo_oe_n;
  assign signal_drop_out_o = q.od_low;
  assign signal_drop_oe_n_o = q.drop_oe_n;
  assign transmit_fault_out_o = q.od_low;
  assign transmit_fault_oe_n_o = q.tflt_oe_n;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Outputs still show their reset values at the first edge after release,
  // so checks against the previous state start only once reset is low.
  bus_wait_a: assert property (
    req && q.wait_r |=> !avs_waitrequest_o)
    else $error("waitrequest did not drop after one cycle");

  laser_off_out_mode_a: assert property (
    !rst_i && !q.cfg3[pin_select_pkg::CFG3_FIN_MODE] |=> !laser_off_oe_n_o)
    else $error("shutdown pin not driven in output mode");

  laser_off_out_fault_a: assert property (
    !q.cfg3[pin_select_pkg::CFG3_FIN_MODE] && internal_fault_i &&
    !q.cfg4[pin_select_pkg::CFG4_NO_LASER_OFF_OUT] |=> laser_off_out_o)
    else $error("fault did not assert shutdown");

  laser_off_out_mask_a: assert property (
    q.cfg4[pin_select_pkg::CFG4_NO_LASER_OFF_OUT] |=> !laser_off_out_o)
    else $error("shutdown asserted while disabled");

  ext_fault_a: assert property (
    q.cfg3[pin_select_pkg::CFG3_FIN_MODE] && q.ef_s[1] &&
    !q.cfg5[pin_select_pkg::CFG5_FLT_POL] ##1
    !q.cfg5[pin_select_pkg::CFG5_FLT_POL] |=> transmit_fault_oe_n_o)
    else $error("external fault not on transmit fault");

  rx_rate_a: assert property (
    !rst_i && !q.cfg3[pin_select_pkg::CFG3_GPO_SEL] |=>
    !general_output_pin_o &&
    general_output_oe_n_o == $past(q.ctrl[0] | q.rx_s[1]))
    else $error("receiver rate output wrong");

  gpo_level_a: assert property (
    q.cfg3[pin_select_pkg::CFG3_GPO_SEL] |=>
    (general_output_pin_o | general_output_oe_n_o) ==
    $past(q.cfg3[pin_select_pkg::CFG3_GPO_LVL]))
    else $error("general output level wrong");

  push_pull_a: assert property (
    general_output_pin_o |-> $past(q.cfg3[pin_select_pkg::CFG3_GPO_SEL]))
    else $error("push-pull drive outside general output mode");

  loss_set_a: assert property (
    received_power_input_i < q.thr |=> q.loss ##1
    ($past(q.cfg6[pin_select_pkg::CFG6_TRS_SEL]) ||
    signal_drop_oe_n_o != $past(q.cfg6[pin_select_pkg::CFG6_LOS_POL])))
    else $error("signal loss not flagged");

  loss_clr_a: assert property (
    received_power_input_i > q.thr |=> !q.loss)
    else $error("signal loss not cleared");

  drop_pol_a: assert property (
    !rst_i && !q.cfg6[pin_select_pkg::CFG6_TRS_SEL] |=>
    signal_drop_oe_n_o ==
    $past(q.loss ^ q.cfg6[pin_select_pkg::CFG6_LOS_POL]))
    else $error("signal loss polarity wrong");

  tx_rate_a: assert property (
    q.cfg6[pin_select_pkg::CFG6_TRS_SEL] |=>
    signal_drop_oe_n_o == $past(q.ctrl[1] | q.tx_s[1]))
    else $error("transmitter rate output wrong");

  tflt_pol_a: assert property (
    !rst_i |=> transmit_fault_oe_n_o ==
    $past(q.flt ^ q.cfg5[pin_select_pkg::CFG5_FLT_POL]))
    else $error("transmit fault polarity wrong");

  od_low_a: assert property (
    !signal_drop_out_o && !transmit_fault_out_o)
    else $error("open-drain output driven high");

  pin_stat_a: assert property (
    avs_read_i && q.wait_r && avs_address_i == pin_select_pkg::STAT_OFS
    |=> avs_readdata_o[pin_select_pkg::ST_DROP] == $past(q.dp_s[1]))
    else $error("drop status does not match pin");

  rx_status_a: assert property (
    avs_read_i && q.wait_r && avs_address_i == pin_select_pkg::STAT_OFS
    |=> avs_readdata_o[pin_select_pkg::ST_RX_PIN] == $past(q.rx_s[1]) &&
    avs_readdata_o[pin_select_pkg::ST_TX_PIN] == $past(q.tx_s[1]))
    else $error("rate input status does not match pins");

  laser_off_out_release_a: assert property (
    !rst_i && q.cfg3[pin_select_pkg::CFG3_FIN_MODE] |=>
    laser_off_oe_n_o && !laser_off_out_o)
    else $error("shutdown pin driven in input mode");

  irq_level_a: assert property (
    !rst_i |=> irq_o == |($past(q.ist) & $past(q.imsk)))
    else $error("interrupt level does not follow status");

  event_set_a: assert property (
    ev != 2'h0 |=> (q.ist & $past(ev)) == $past(ev))
    else $error("event lost against a clear");

  ist_clear_a: assert property (
    avs_write_i && !q.wait_r && ev == 2'h0 &&
    avs_address_i == pin_select_pkg::IST_OFS |=>
    (q.ist & $past(avs_writedata_i[1:0])) == 2'h0)
    else $error("interrupt status not cleared");

  cfg_write_a: assert property (
    avs_write_i && !q.wait_r && avs_address_i == pin_select_pkg::CFG4_OFS
    |=> q.cfg4 == $past(avs_writedata_i[7:0]))
    else $error("configuration write did not land");

  laser_off_out_c: cover property (laser_off_out_o);
  loss_c: cover property (q.loss ##1 !q.loss);
  irq_c: cover property (irq_o);
  gpo_pp_c: cover property (general_output_pin_o && !general_output_oe_n_o);
  ext_c: cover property (q.cfg3[pin_select_pkg::CFG3_FIN_MODE] && q.ef_s[1]);

endmodule : optical_pin_select
`default_nettype wire

/* dv/pin_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Host and laser-driver side: pull-ups on every open-drain wire, the host's
// rate and fault drivers, and an optional pull-down wire-ORed onto the drop
// pin.
module pin_host_model (
  input wire logic rx_i,
  input wire logic tx_i,
  input wire logic ext_i,
  input wire logic pull_i,
  input wire logic lo_i,
  input wire logic lo_n_i,
  input wire logic go_i,
  input wire logic go_n_i,
  input wire logic dro_i,
  input wire logic dro_n_i,
  input wire logic fo_i,
  input wire logic fo_n_i,
  output logic rxp_o,
  output logic txp_o,
  output logic p12_o,
  output logic gw_o,
  output logic dw_o,
  output logic fw_o
);
  assign rxp_o = rx_i;
  assign txp_o = tx_i;
  // Once the device lets go of pin twelve, the host's fault source owns it.
  assign p12_o = lo_n_i ? ext_i : lo_i;
  assign gw_o = go_n_i ? 1'h1 : go_i;
  // Any party may pull the shared drop wire low, whatever the device does.
  assign dw_o = (dro_n_i ? 1'h1 : dro_i) & ~pull_i;
  assign fw_o = fo_n_i ? 1'h1 : fo_i;
endmodule : pin_host_model
`default_nettype wire

/* dv/optical_module_pin_function_select_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module optical_module_pin_function_select_bench;
  logic clk_i, rst_i, rd_i, wr_i, flt, rx, tx, ext, pull;
  logic [5:0] adr;
  logic [31:0] wd, rdat, q;
  logic [7:0] pwr;
  logic wt, irq, lo, lo_n, go, go_n, dro, dro_n, fo, fo_n;
  logic rxp, txp, p12, gw, dw, fw;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [5:0] offs [7] = '{pin_select_pkg::CFG3_OFS, pin_select_pkg::CFG4_OFS,
    pin_select_pkg::CFG5_OFS, pin_select_pkg::CFG6_OFS,
    pin_select_pkg::CTRL_OFS, pin_select_pkg::IMSK_OFS, 6'h24};
  optical_pin_select DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
    .internal_fault_i(flt), .received_power_input_i(pwr),
    .receiver_rate_pin_i(rxp), .transmitter_rate_pin_i(txp),
    .external_fault_in_i(p12), .laser_off_out_o(lo), .laser_off_oe_n_o(lo_n),
    .general_output_pin_o(go), .general_output_oe_n_o(go_n),
    .signal_drop_pin_i(dw), .signal_drop_out_o(dro),
    .signal_drop_oe_n_o(dro_n), .transmit_fault_out_o(fo),
    .transmit_fault_oe_n_o(fo_n));
  pin_host_model host (.rx_i(rx), .tx_i(tx), .ext_i(ext), .pull_i(pull),
    .lo_i(lo), .lo_n_i(lo_n), .go_i(go), .go_n_i(go_n), .dro_i(dro),
    .dro_n_i(dro_n), .fo_i(fo), .fo_n_i(fo_n), .rxp_o(rxp), .txp_o(txp),
    .p12_o(p12), .gw_o(gw), .dw_o(dw), .fw_o(fw));
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // The whole run needs a few hundred cycles; this ceiling only cuts a hang.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    rd_i <= !w;
    wr_i <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wt !== 1'h0);
    q = rdat;
    rd_i <= 1'h0;
    wr_i <= 1'h0;
    chk("wait_cycles", n, 32'h2);
  endtask : bus
  task automatic settle();
    repeat (6) @(posedge clk_i);
    chk("drop_out", dro, 32'h0);
    chk("fault_out", fo, 32'h0);
  endtask : settle
  task automatic t_reset();
    bus(1'h1, 6'h24, 32'hFFFFFFFF);
    foreach (offs[i]) begin
      bus(1'h0, offs[i], 32'h0);
      chk("reset_value", q, 32'h0);
    end
    bus(1'h0, pin_select_pkg::THR_OFS, 32'h0);
    chk("threshold", q, 32'h80);
    chk("pin12_oe_n", lo_n, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_shutdown();
    bus(1'h1, pin_select_pkg::IMSK_OFS, 32'h1);
    flt <= 1'h1;
    settle();
    chk("laser_off", lo, 32'h1);
    chk("fault_wire", fw, 32'h1);
    chk("irq", irq, 32'h1);
    bus(1'h1, pin_select_pkg::IST_OFS, 32'h1);
    bus(1'h1, pin_select_pkg::CFG4_OFS, 32'h80);
    bus(1'h1, pin_select_pkg::CFG5_OFS, 32'h10);
    settle();
    chk("irq_clear", irq, 32'h0);
    chk("laser_off", lo, 32'h0);
    chk("fault_wire", fw, 32'h0);
    flt <= 1'h0;
    bus(1'h1, pin_select_pkg::CFG4_OFS, 32'h0);
    bus(1'h1, pin_select_pkg::CFG5_OFS, 32'h0);
    bus(1'h1, pin_select_pkg::CFG3_OFS, 32'h4);
    ext <= 1'h1;
    settle();
    chk("pin12_oe_n", lo_n, 32'h1);
    chk("fault_wire", fw, 32'h1);
    ext <= 1'h0;
    settle();
    chk("fault_wire", fw, 32'h0);
    // The external fault raised the fault event again; later tests need it gone.
    bus(1'h1, pin_select_pkg::IST_OFS, 32'h1);
    settle();
    chk("irq_clear", irq, 32'h0);
    $display("shutdown test done");
  endtask : t_shutdown
  task automatic t_rate(input logic txm);
    bus(1'h1, pin_select_pkg::CFG3_OFS, 32'h2);
    bus(1'h1, pin_select_pkg::CFG6_OFS, {29'h0, txm, 2'h0});
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, pin_select_pkg::CTRL_OFS, 32'(i & 1) << txm);
      rx <= i[1] & !txm;
      tx <= i[1] & txm;
      settle();
      bus(1'h0, pin_select_pkg::STAT_OFS, 32'h0);
      chk("rate_status", q[txm], i[1]);
      if (txm) begin
        chk("tx_rate_wire", dw, 32'(i != 0));
      end else begin
        chk("rx_rate_wire", gw, 32'(i != 0));
        chk("rx_rate_oe_n", go_n, 32'(i != 0));
      end
    end
    bus(1'h1, pin_select_pkg::CTRL_OFS, 32'h0);
    $display("rate test done");
  endtask : t_rate
  task automatic t_gpo();
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, pin_select_pkg::CFG3_OFS, 32'h10 | 32'(i));
      settle();
      chk("gpo_wire", gw, i[0]);
      chk("gpo_oe_n", go_n, i[0] & !i[1]);
    end
    $display("general output test done");
  endtask : t_gpo
  task automatic t_loss();
    bus(1'h1, pin_select_pkg::CFG6_OFS, 32'h0);
    pwr <= 8'h40;
    settle();
    chk("drop_wire", dw, 32'h1);
    chk("irq_masked", irq, 32'h0);
    bus(1'h1, pin_select_pkg::IMSK_OFS, 32'h2);
    settle();
    chk("irq_loss", irq, 32'h1);
    bus(1'h1, pin_select_pkg::IST_OFS, 32'h2);
    pwr <= 8'h80;
    settle();
    chk("irq_clear", irq, 32'h0);
    chk("drop_equal", dw, 32'h1);
    pwr <= 8'h81;
    settle();
    chk("drop_wire", dw, 32'h0);
    bus(1'h1, pin_select_pkg::CFG6_OFS, 32'h8);
    settle();
    chk("drop_wire", dw, 32'h1);
    pull <= 1'h1;
    settle();
    bus(1'h0, pin_select_pkg::STAT_OFS, 32'h0);
    chk("drop_status", q[2], 32'h0);
    pull <= 1'h0;
    $display("loss test done");
  endtask : t_loss
  initial begin
    rst_i = 1'h1;
    {rd_i, wr_i, flt, rx, tx, ext, pull} = 7'h0;
    adr = 6'h0;
    wd = 32'h0;
    pwr = 8'hC0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_shutdown();
    t_rate(1'h0);
    t_gpo();
    t_loss();
    t_rate(1'h1);
    end_of_test();
  end
endmodule : optical_module_pin_function_select_bench
`default_nettype wire
